// >>> safe_torque_off_monitor.sv
// Dual-channel safe torque off input filter, power cut and monitor outputs.
// Assumes pin inputs are asynchronous levels, high meaning the contact is closed.
// How it works
// - Channel one demands shut-off while its input is open and permits driving only while closed.
// - Channel two demands shut-off while its input is open and permits driving only while closed.
// - The first monitor output conducts while channel one is shut off and is open when released.
// - The second monitor output conducts while channel two is shut off and is open when released.
// - Motor power is cut when either channel is off, and the cross path conducts only when both are off.
// - A channel shutting off after its filter while no channel was off and the motor still turns raises the timing error alarm.
`timescale 1ns/1ns
`default_nettype none
module safe_torque_off_monitor
   import shutoff_pkg::*;
#(
   parameter int FILTER_CYCLES = TEST_PULSE_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Safety contacts, high while closed against the common
   input wire logic safety_input_one,
   input wire logic safety_input_two,
   // Motor state from the drive
   input wire logic motorRotating,
   // Power stage and monitors
   output logic powerEnable,
   output logic shutoff_monitor_one,
   output logic shutoff_monitor_two,
   output logic shutoffMonitorCross,
   output logic shutoff_timing_error_alarm
);

   // ----------------------------------------
   // Local constants
   // ----------------------------------------
   localparam int NUM_CHAN = 2;
   // Filter limit cut to the counter width on purpose
   localparam logic [FILTER_WIDTH-1:0] FILTER_LIMIT = FILTER_WIDTH'(FILTER_CYCLES);

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   // Two synchroniser stages show the same level
   function automatic logic levelAgreed(input logic early, input logic late);
      return early == late;
   endfunction : levelAgreed

   // At least one channel is shut off
   function automatic logic anyChannel(input logic [NUM_CHAN-1:0] flags);
      return |flags;
   endfunction : anyChannel

   // Every channel is shut off
   function automatic logic allChannels(input logic [NUM_CHAN-1:0] flags);
      return &flags;
   endfunction : allChannels

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [NUM_CHAN-1:0] rawIn;
   wire logic [NUM_CHAN-1:0] syncMid;
   wire logic [NUM_CHAN-1:0] syncOld;
   assign rawIn = {safety_input_two, safety_input_one};

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++)
      begin : gen_sync
         logic s1_r;
         logic s2_r;
         logic s3_r;
         // Not reset: three reset edges flush them
         always_ff @(posedge clk)
         begin
            s1_r <= rawIn[g];
            s2_r <= s1_r;
            s3_r <= s2_r;
         end
         assign syncMid[g] = s2_r;
         assign syncOld[g] = s3_r;
      end
   endgenerate

   // ----------------------------------------
   // Open-time filters
   // ----------------------------------------
   wire logic [NUM_CHAN-1:0] pinSteady;
   wire logic [NUM_CHAN-1:0] pinOpen;
   wire logic [NUM_CHAN-1:0] pinClosed;
   wire logic [NUM_CHAN-1:0] openLong;

   generate
      for (g = 0; g < NUM_CHAN; g++)
      begin : gen_filter
         logic [FILTER_WIDTH-1:0] cnt_r;
         logic [FILTER_WIDTH-1:0] cnt_nxt;
         logic expired;
         assign pinSteady[g] = levelAgreed(syncMid[g], syncOld[g]);
         assign pinOpen[g] = pinSteady[g] & ~syncOld[g];
         assign pinClosed[g] = pinSteady[g] & syncOld[g];
         assign expired = (cnt_r >= FILTER_LIMIT);
         // Saturates; any close or disagreement starts it over
         assign cnt_nxt = pinOpen[g] ? (expired ? cnt_r : cnt_r + 1'b1) : '0;
         assign openLong[g] = pinOpen[g] & expired;
         always_ff @(posedge clk)
         begin
            if (srst)
               cnt_r <= '0;
            else
               cnt_r <= cnt_nxt;
         end
      end
   endgenerate

   // ----------------------------------------
   // Channel shut-off state
   // ----------------------------------------
   wire logic [NUM_CHAN-1:0] chanOff;

   generate
      for (g = 0; g < NUM_CHAN; g++)
      begin : gen_state
         logic off_r;
         logic off_nxt;
         // Release at once on a steady close, shut off after a long open
         assign off_nxt = pinClosed[g] ? 1'b0 : (openLong[g] ? 1'b1 : off_r);
         always_ff @(posedge clk)
         begin
            if (srst)
               off_r <= RESET_SHUTOFF;
            else
               off_r <= off_nxt;
         end
         assign chanOff[g] = off_r;
      end
   endgenerate

   // ----------------------------------------
   // Channel combination
   // ----------------------------------------
   logic anyOff;
   logic bothOff;
   logic newOff;
   logic alarmSet;
   logic prevAnyOff_r;
   assign anyOff = anyChannel(chanOff);
   assign bothOff = allChannels(chanOff);
   assign newOff = anyOff & ~prevAnyOff_r;
   assign alarmSet = newOff & motorRotating;

   // ----------------------------------------
   // Previous shut-off state
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         prevAnyOff_r <= RESET_SHUTOFF;
      else
         prevAnyOff_r <= anyOff;
   end

   // ----------------------------------------
   // Power stage enable
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         powerEnable <= 1'b0;
      else
         powerEnable <= ~anyOff;
   end

   // ----------------------------------------
   // First monitor output
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         shutoff_monitor_one <= RESET_SHUTOFF;
      else
         shutoff_monitor_one <= chanOff[0];
   end

   // ----------------------------------------
   // Second monitor output
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         shutoff_monitor_two <= RESET_SHUTOFF;
      else
         shutoff_monitor_two <= chanOff[1];
   end

   // ----------------------------------------
   // Cross path between the monitors
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         shutoffMonitorCross <= RESET_SHUTOFF;
      else
         shutoffMonitorCross <= bothOff;
   end

   // ----------------------------------------
   // Timing error alarm
   // ----------------------------------------
   // Sticky until reset
   always_ff @(posedge clk)
   begin
      if (srst)
         shutoff_timing_error_alarm <= 1'b0;
      else if (alarmSet)
         shutoff_timing_error_alarm <= 1'b1;
   end

endmodule : safe_torque_off_monitor
`default_nettype wire

// >>> safe_torque_off_monitor_test.sv
// Bench for the torque off monitor with a relay model in front.
// Assumes a shortened filter of 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module safe_torque_off_monitor_test;
   localparam int F = 20;
   logic clk = 1'b0, srst = 1'b1, demandOff = 1'b1, onlyOne = 1'b0, onlyTwo = 1'b0;
   logic pulse = 1'b0, motorRotating = 1'b0;
   logic pe, m1, m2, mx, al;
   wire logic s1, s2;
   int bad_count = 0, n_checks = 0;
   initial forever #10 clk = ~clk;
   safety_relay_model safety_relay_model_inst (.clk(clk), .demandOff(demandOff), .onlyOne(onlyOne),
      .onlyTwo(onlyTwo), .pulse(pulse),
      .safety_input_one(s1), .safety_input_two(s2));
   safe_torque_off_monitor #(.FILTER_CYCLES(F)) safe_torque_off_monitor_inst (.clk(clk), .srst(srst),
      .safety_input_one(s1), .safety_input_two(s2), .motorRotating(motorRotating), .powerEnable(pe),
      .shutoff_monitor_one(m1), .shutoff_monitor_two(m2), .shutoffMonitorCross(mx), .shutoff_timing_error_alarm(al));
   task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Drive demand, fault, pulse, rotation, then wait and compare
   task automatic step(input logic [3:0] v, input int n, input logic [4:0] exp);
      @(posedge clk);
      {demandOff, onlyOne, pulse, motorRotating} <= v;
      repeat (n) @(posedge clk);
      #1;
      chk({pe, m1, m2, mx, al}, exp);
   endtask : step
   task automatic t_pulse;
      step(4'h2, F - 1, 5'h10);
      step(4'h0, 3 * F, 5'h10);
   endtask : t_pulse
   task automatic t_one;
      step(4'hc, F + 10, 5'h08);
      step(4'h0, 10, 5'h10);
   endtask : t_one
   task automatic t_two;
      @(posedge clk);
      onlyTwo <= 1'b1;
      step(4'h8, F + 10, 5'h04);
      step(4'h0, 10, 5'h10);
      @(posedge clk);
      onlyTwo <= 1'b0;
   endtask : t_two
   task automatic t_both;
      step(4'h8, F + 10, 5'h0e);
      step(4'h0, 10, 5'h10);
   endtask : t_both
   task automatic t_alarm;
      step(4'h9, F + 10, 5'h0f);
      step(4'h0, 10, 5'h11);
   endtask : t_alarm
   task automatic t_reset;
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk({pe, m1, m2, mx, al}, 5'h0e);
      @(posedge clk);
      srst <= 1'b0;
      step(4'h0, 10, 5'h10);
   endtask : t_reset
   task automatic complete_run;
      if (bad_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      step(4'h0, 10, 5'h10);
      t_pulse();
      t_one();
      t_two();
      t_both();
      t_alarm();
      t_reset();
      complete_run();
   end
endmodule : safe_torque_off_monitor_test
`default_nettype wire

// >>> safety_relay_model.sv
// Safety relay stand-in driving both contacts, high while closed.
// Assumes the bench keeps pulse no longer than the filter length.
`timescale 1ns/1ns
`default_nettype none
module safety_relay_model
(
   // Clock
   input wire logic clk,
   // Requests from the bench
   input wire logic demandOff,
   input wire logic onlyOne,
   input wire logic onlyTwo,
   input wire logic pulse,
   // Contacts towards the block
   output logic safety_input_one,
   output logic safety_input_two
);
   always_ff @(posedge clk)
   begin
      safety_input_one <= !((demandOff && !onlyTwo) || pulse);
      safety_input_two <= !((demandOff && !onlyOne) || pulse);
   end
endmodule : safety_relay_model
`default_nettype wire

// >>> shutoff_pkg.sv
// Package for the safe torque off monitor: timing constants.
// Assumes a 50 MHz system clock.
package shutoff_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int TEST_PULSE_MAX_US = 1000;
   // Filter length: an off pulse of this length or shorter is ignored
   localparam int TEST_PULSE_CYCLES = (TEST_PULSE_MAX_US * (CLK_HZ / 1000000));
   localparam int FILTER_WIDTH = 17;
   // Reset values: shut-off until inputs are proven closed
   localparam logic RESET_SHUTOFF = 1'b1;
endpackage : shutoff_pkg

// >>> sto_monitor_asserts.sv
// Port checker for the torque off monitor.
// Assumes one clock and synchronous srst.
`timescale 1ns/1ns
`default_nettype none
module sto_monitor_asserts
   import shutoff_pkg::*;
#(
   parameter int FILTER_CYCLES = TEST_PULSE_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Safety contacts and motor state
   input wire logic safety_input_one,
   input wire logic safety_input_two,
   input wire logic motorRotating,
   // Design outputs
   input wire logic powerEnable,
   input wire logic shutoff_monitor_one,
   input wire logic shutoff_monitor_two,
   input wire logic shutoffMonitorCross,
   input wire logic shutoff_timing_error_alarm
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   power_gate_a: assert property (powerEnable == !(shutoff_monitor_one || shutoff_monitor_two))
      else $error("power");
   cross_path_a: assert property (shutoffMonitorCross == (shutoff_monitor_one && shutoff_monitor_two))
      else $error("cross");
   one_open_a: assert property ($rose(shutoff_monitor_one) |->
      !$past(safety_input_one, FILTER_CYCLES)) else $error("one");
   two_open_a: assert property ($rose(shutoff_monitor_two) |->
      !$past(safety_input_two, FILTER_CYCLES)) else $error("two");
   one_close_a: assert property ($fell(shutoff_monitor_one) |->
      $past(safety_input_one, 4) && $past(safety_input_one, 5)) else $error("release one");
   two_close_a: assert property ($fell(shutoff_monitor_two) |->
      $past(safety_input_two, 4) && $past(safety_input_two, 5)) else $error("release two");
   alarm_cause_a: assert property ($rose(shutoff_timing_error_alarm) |-> $past(motorRotating))
      else $error("alarm");
   alarm_hold_a: assert property (shutoff_timing_error_alarm |=> shutoff_timing_error_alarm)
      else $error("sticky");
endmodule : sto_monitor_asserts
bind safe_torque_off_monitor sto_monitor_asserts #(.FILTER_CYCLES(FILTER_CYCLES)) sto_monitor_asserts_inst (
   .clk(clk),
   .srst(srst),
   .safety_input_one(safety_input_one),
   .safety_input_two(safety_input_two),
   .motorRotating(motorRotating),
   .powerEnable(powerEnable),
   .shutoff_monitor_one(shutoff_monitor_one),
   .shutoff_monitor_two(shutoff_monitor_two),
   .shutoffMonitorCross(shutoffMonitorCross),
   .shutoff_timing_error_alarm(shutoff_timing_error_alarm)
);
`default_nettype wire
